// ---- rtl/rfhc_defines.vh ----
// Constants for the radio frame-handling control block
`ifndef RFHC_DEFINES_VH
`define RFHC_DEFINES_VH

// Register indices; the byte address is four times the index
`define RFHC_IDX_CTRL_A     16'h6189
`define RFHC_IDX_CTRL_B     16'h618a
`define RFHC_IDX_MASK       16'h618b
`define RFHC_IDX_MASK_SET   16'h618c
`define RFHC_IDX_MASK_CLR   16'h618d
`define RFHC_IDX_STROBE     16'h61f0
`define RFHC_IDX_RSSI       16'h61f1

// Field positions in frame_handling_ctrl_a
`define RFHC_A_AUTOACK      5
`define RFHC_A_PEAK         4
`define RFHC_A_RXM_HI       3
`define RFHC_A_RXM_LO       2
`define RFHC_A_TXM_HI       1
`define RFHC_A_TXM_LO       0

// Field positions in frame_handling_ctrl_b
`define RFHC_B_PEND_FORCE   2
`define RFHC_B_UF_BYPASS    1
`define RFHC_B_MASK_ON_TX   0

// Bit of the strobe register that fires the transmit-on strobe
`define RFHC_STB_TXON       0
// Mask bit set by the transmit-on strobe
`define RFHC_MASK_TX_BIT    6

// Reset values
`define RFHC_CTRL_A_RST     8'h40
`define RFHC_CTRL_B_RST     8'h01
`define RFHC_MASK_RST       8'h00

// Mode codes for the receive and transmit fields
`define RFHC_RXM_NORMAL     2'h0
`define RFHC_RXM_LOOP       2'h2
`define RFHC_RXM_NOSYNC     2'h3
`define RFHC_TXM_NORMAL     2'h0
`define RFHC_TXM_LOOP       2'h2
`define RFHC_TXM_PRBS       2'h3

// Acknowledge turnaround: 12 symbols of 16 us, at a 25 MHz clock
`define RFHC_SYMBOLS_ACK    12
`define RFHC_SYMBOL_NS      16000
`define RFHC_CLK_MHZ        25
// 12 x 16000 ns x 25 / 1000 = 4800 cycles, sized for the 16-bit turnaround counter
`define RFHC_ACK_DELAY_CYC  16'd4800

`endif

// ---- rtl/rfhc_top.v ----
// Frame-handling control registers and their radio-side effects
`timescale 1ns/100ps
`include "rfhc_defines.vh"

module rfhc_top #(
    parameter [15:0] ACK_DELAY_CYC = `RFHC_ACK_DELAY_CYC  // Long count, shortened in simulation
) (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,

    // Bus address phase
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    // Bus data phase and response
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,

    // Frame status from the receiver
    input  wire        frame_done,
    input  wire        frame_accepted,
    input  wire        frame_ack_req,
    input  wire        frame_crc_ok,
    input  wire        fsm_pending,
    // Signal strength and FIFO status
    input  wire [7:0]  rssi_sample,
    input  wire        rssi_valid,
    input  wire        rx_fifo_overflow,
    input  wire        tx_fifo_underflow,

    // Acknowledge and strength controls
    output reg         ack_start,
    output reg         ack_pending,
    output reg  [7:0]  rssi_value,
    // Receiver controls
    output reg         rx_sfd_search_en,
    output reg         rx_fifo_wrap,
    output reg         rx_stop,
    // Transmitter controls
    output reg         tx_fifo_loop,
    output reg         tx_prbs_sel,
    output reg         tx_length_exact,
    output reg         tx_underflow_flag,
    output reg         tx_abort,
    // Receive-enable mask and its summary
    output reg         rx_on_request,
    output reg  [7:0]  receive_enable_mask
);

    // Control and mask storage
    reg  [7:0]  ctrl_a_reg;            // frame_handling_ctrl_a
    reg  [7:0]  ctrl_a_next;
    reg  [2:0]  ctrl_b_reg;            // frame_handling_ctrl_b, low bits only
    reg  [2:0]  ctrl_b_next;
    reg  [7:0]  mask_next;             // Next value of the receive-enable mask
    // Strength tracking
    reg  [7:0]  peak_reg;              // Highest strength since peak-hold began
    reg  [7:0]  peak_next;
    reg  [7:0]  latest_reg;            // Most recent strength sample
    // Acknowledge timing
    reg  [15:0] ack_cnt_reg;           // Cycles left before the ack starts
    reg  [15:0] ack_cnt_next;
    reg         ack_start_next;

    // Reset value of the stored low bits of frame_handling_ctrl_b
    localparam [7:0] CTRL_B_RST = `RFHC_CTRL_B_RST;

    // The address and the data of one transfer stand in different cycles
    // Captured address phase, used in the data phase
    reg         wr_pend_reg;           // A write waits for its data
    reg  [29:0] wr_idx_reg;            // Word index of that write
    reg  [31:0] rdata_next;

    // Decoded fields
    wire [1:0]  rx_mode;
    wire [1:0]  tx_mode;
    wire        autoack_on;
    wire        peak_on;
    wire        addr_phase;
    wire        wr_a;
    wire        wr_b;
    wire        wr_set;
    wire        wr_clr;
    wire        wr_stb;
    wire        txon_strobe;
    wire [7:0]  wbyte;

    // Field views of the stored control bits
    assign rx_mode    = ctrl_a_reg[`RFHC_A_RXM_HI:`RFHC_A_RXM_LO];
    assign tx_mode    = ctrl_a_reg[`RFHC_A_TXM_HI:`RFHC_A_TXM_LO];
    assign autoack_on = ctrl_a_reg[`RFHC_A_AUTOACK];
    assign peak_on    = ctrl_a_reg[`RFHC_A_PEAK];

    // A transfer is taken when selected, active and the bus is ready
    assign addr_phase = hsel & htrans[1] & hready;

    // Only the low byte of the write data is used
    assign wbyte  = hwdata[7:0];

    // Word indices of the writable registers, one 16-bit slot per decoder
    localparam [79:0] WR_IDX_LIST = {`RFHC_IDX_STROBE,      // Slot 4
                                     `RFHC_IDX_MASK_CLR,    // Slot 3
                                     `RFHC_IDX_MASK_SET,    // Slot 2
                                     `RFHC_IDX_CTRL_B,      // Slot 1
                                     `RFHC_IDX_CTRL_A};     // Slot 0
    wire [4:0]  wr_hit;                // Data-phase write strobe per slot

    // One index decoder per writable register; a write lands at the end of its data phase
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_wr_match
            rfhc_word_match #(
                .IDX (WR_IDX_LIST[g*16 +: 16])
            ) rfhc_word_match_inst (
                .pend (wr_pend_reg),
                .idx  (wr_idx_reg),
                .hit  (wr_hit[g])
            );
        end
    endgenerate

    // Named strobes for the register processes
    assign wr_a   = wr_hit[0];
    assign wr_b   = wr_hit[1];
    assign wr_set = wr_hit[2];
    assign wr_clr = wr_hit[3];
    assign wr_stb = wr_hit[4];

    // Transmit-on strobe fires on a write of one to its strobe bit
    assign txon_strobe = wr_stb & wbyte[`RFHC_STB_TXON];

    // Bus slave: zero wait states, so hreadyout stays high and the answer is always OKAY
    // Read data comes from a flip-flop loaded in the address phase, so no wait state is needed
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 30'h00000000;
            hrdata      <= 32'h00000000;
            // Ready stands high in reset, so a transfer may follow the release at once
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            // A write is remembered for one cycle only, its data phase
            wr_pend_reg <= addr_phase & hwrite;
            wr_idx_reg  <= haddr[31:2];
            hrdata      <= rdata_next;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end
    end

    // Read mux, sampled at the address phase so data stands through the data phase
    always @* begin
        rdata_next = 32'h00000000;
        // Misaligned reads return zero instead of a shifted byte
        if (addr_phase & !hwrite & (haddr[1:0] == 2'h0)) begin
            case (haddr[31:2])
                {14'h0000, `RFHC_IDX_CTRL_A}: rdata_next = {24'h000000, ctrl_a_reg};
                // Bits 7..3 are not stored, so they read as zero
                {14'h0000, `RFHC_IDX_CTRL_B}: rdata_next = {29'h00000000, ctrl_b_reg};
                {14'h0000, `RFHC_IDX_MASK}:   rdata_next = {24'h000000, receive_enable_mask};
                // Strength reads show the report selected by peak-hold
                {14'h0000, `RFHC_IDX_RSSI}:   rdata_next = {24'h000000, rssi_value};
                // Set, clear and strobe registers read as zero, as do unmapped words
                default:                      rdata_next = 32'h00000000;
            endcase
        end
    end

    // Control register writes; the reserved receive and transmit codes are stored as written
    always @* begin
        // Hold unless written
        ctrl_a_next = ctrl_a_reg;
        ctrl_b_next = ctrl_b_reg;
        if (wr_a) begin
            // Bits 7 and 6 of control a are kept as plain storage
            ctrl_a_next = wbyte;
        end
        if (wr_b) begin
            // Upper bits of the written byte are dropped
            ctrl_b_next = wbyte[2:0];
        end
    end

    // Receive-enable mask: bus set and clear win over the strobe on a shared bit
    // One bus cannot write and fire the strobe in one cycle; the order still fixes who wins
    always @* begin
        mask_next = receive_enable_mask;
        if (txon_strobe & ctrl_b_reg[`RFHC_B_MASK_ON_TX]) begin
            mask_next[`RFHC_MASK_TX_BIT] = 1'b1;
        end
        // Set register ORs the written byte into the mask
        if (wr_set) begin
            mask_next = mask_next | wbyte;
        end
        // Clear register removes the written ones
        if (wr_clr) begin
            mask_next = mask_next & ~wbyte;
        end
    end

    // Peak tracking restarts from the newest sample when peak-hold is off
    // Samples are signed, so a negative reading never beats a positive peak
    always @* begin
        peak_next = peak_reg;
        if (!peak_on) begin
            peak_next = latest_reg;
        end else if (rssi_valid && ($signed(rssi_sample) > $signed(peak_reg))) begin
            peak_next = rssi_sample;
        end
    end

    // Acknowledge turnaround timer
    // A new good frame restarts the count; of two close frames only the last is acknowledged
    always @* begin
        ack_cnt_next   = ack_cnt_reg;
        ack_start_next = 1'b0;
        if (!autoack_on) begin
            // Clearing autoack also drops a pending ack
            ack_cnt_next = 16'h0000;
        end else if (frame_done & frame_accepted & frame_ack_req & frame_crc_ok) begin
            ack_cnt_next = ACK_DELAY_CYC;
        end else if (ack_cnt_reg != 16'h0000) begin
            // Count down toward the pulse
            ack_cnt_next = ack_cnt_reg - 16'h0001;
            // Pulse on the last cycle of the wait
            if (ack_cnt_reg == 16'h0001) begin
                ack_start_next = 1'b1;
            end
        end
    end

    // Register state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Control fields start from their reset codes
            ctrl_a_reg          <= `RFHC_CTRL_A_RST;
            ctrl_b_reg          <= CTRL_B_RST[2:0];
            // Empty mask: no receiver request after reset
            receive_enable_mask <= `RFHC_MASK_RST;
            latest_reg          <= 8'h00;
            peak_reg            <= 8'h00;
            ack_cnt_reg         <= 16'h0000;
            ack_start           <= 1'b0;
        end else begin
            ctrl_a_reg          <= ctrl_a_next;
            ctrl_b_reg          <= ctrl_b_next;
            receive_enable_mask <= mask_next;

            // Latest strength only moves on a valid sample
            if (rssi_valid) begin
                latest_reg <= rssi_sample;
            end
            peak_reg            <= peak_next;
            ack_cnt_reg         <= ack_cnt_next;
            ack_start           <= ack_start_next;
        end
    end

    // Radio-side control outputs, each from its own flip-flop
    // Registering the levels costs a cycle of latency but keeps decode glitches off the radio
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_pending       <= 1'b0;
            rssi_value        <= 8'h00;
            // Search stays enabled in reset, as in the normal receive mode
            rx_sfd_search_en  <= 1'b1;
            rx_fifo_wrap      <= 1'b0;
            rx_stop           <= 1'b0;
            tx_fifo_loop      <= 1'b0;
            tx_prbs_sel       <= 1'b0;
            tx_length_exact   <= 1'b0;
            tx_underflow_flag <= 1'b0;
            tx_abort          <= 1'b0;
            rx_on_request     <= 1'b0;
        end else begin
            // Forced pending bit overrides the state machine and filtering
            ack_pending      <= ctrl_b_reg[`RFHC_B_PEND_FORCE] | fsm_pending;
            // Reported strength follows the peak-hold selection
            rssi_value       <= peak_on ? peak_reg : latest_reg;

            // Only code 11 stops the start-of-frame search; 01 behaves as normal
            rx_sfd_search_en <= (rx_mode != `RFHC_RXM_NOSYNC);
            rx_fifo_wrap     <= (rx_mode == `RFHC_RXM_LOOP);
            // Overflow halts reception except while the FIFO loops
            rx_stop          <= rx_fifo_overflow & (rx_mode != `RFHC_RXM_LOOP);

            // Reserved code 01 falls into the normal decode in both mode fields
            tx_fifo_loop     <= (tx_mode == `RFHC_TXM_LOOP);
            tx_prbs_sel      <= (tx_mode == `RFHC_TXM_PRBS);
            // Bypass set: the byte count comes from the frame-length field
            tx_length_exact  <= ctrl_b_reg[`RFHC_B_UF_BYPASS];

            // Underflow is meaningless when looping or sending pseudorandom data
            tx_underflow_flag <= tx_fifo_underflow & tx_mode[1] == 1'b0;
            // Abort only in the FIFO-driven modes and only without the bypass
            tx_abort         <= tx_fifo_underflow & !tx_mode[1]
                                & !ctrl_b_reg[`RFHC_B_UF_BYPASS];

            // Any set mask bit keeps the receiver requested on
            rx_on_request    <= (receive_enable_mask != 8'h00);
        end
    end

endmodule // rfhc_top

// Write-strobe decoder: one register index against the captured word index
module rfhc_word_match #(
    parameter [15:0] IDX = 16'h0000    // Register index this decoder answers to
) (
    input  wire        pend,           // A write data phase is under way
    input  wire [29:0] idx,            // Word index captured in the address phase
    output wire        hit             // The pending write targets this register
);

    // Upper index bits must be zero, so aliases higher in the address space are ignored
    assign hit = pend & (idx == {14'h0000, IDX});

endmodule // rfhc_word_match

// ---- bench/rfhc_checker.sv ----
// Port-level assertions for the frame-handling control block
`timescale 1ns/100ps
module rfhc_checker #(
    parameter [15:0] ACK_DELAY_CYC = 16'd10  // Same turnaround as the design
) (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       frame_done,
    input wire logic       frame_accepted,
    input wire logic       frame_ack_req,
    input wire logic       frame_crc_ok,
    input wire logic       tx_fifo_underflow,
    input wire logic       ack_start,
    input wire logic       rx_sfd_search_en,
    input wire logic       rx_fifo_wrap,
    input wire logic       rx_stop,
    input wire logic       tx_fifo_loop,
    input wire logic       tx_prbs_sel,
    input wire logic       tx_length_exact,
    input wire logic       tx_underflow_flag,
    input wire logic       tx_abort,
    input wire logic       rx_on_request,
    input wire logic [7:0] receive_enable_mask
);
    // A frame that deserves an acknowledgement
    wire good_frame = frame_done & frame_accepted & frame_ack_req & frame_crc_ok;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_ack_cause;
        ack_start |-> $past(good_frame, ACK_DELAY_CYC + 1);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack pulse without a good frame");
    property p_ack_pulse;
        ack_start |=> !ack_start;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack pulse too long");
    property p_wrap_sfd;
        rx_fifo_wrap |-> rx_sfd_search_en;
    endproperty
    a_wrap_sfd: assert property (p_wrap_sfd) else $error("loop mode lost frame search");
    // Three stable cycles cover the one-cycle latency of the levels
    property p_wrap_nostop;
        rx_fifo_wrap [*3] |-> !rx_stop;
    endproperty
    a_wrap_nostop: assert property (p_wrap_nostop) else $error("loop mode stopped");
    property p_loop_noflag;
        tx_fifo_loop [*3] |-> !tx_underflow_flag && !tx_abort;
    endproperty
    a_loop_noflag: assert property (p_loop_noflag) else $error("loop mode flagged underflow");
    property p_mode_excl;
        !(tx_fifo_loop && tx_prbs_sel);
    endproperty
    a_mode_excl: assert property (p_mode_excl) else $error("two transmit modes at once");
    property p_bypass_noabort;
        tx_length_exact [*3] |-> !tx_abort;
    endproperty
    a_bypass_noabort: assert property (p_bypass_noabort) else $error("abort with bypass set");
    property p_abort_cause;
        (tx_fifo_underflow && !tx_length_exact && !tx_fifo_loop && !tx_prbs_sel) [*3] |-> tx_abort;
    endproperty
    a_abort_cause: assert property (p_abort_cause) else $error("underflow did not abort");
    property p_rx_on;
        rx_on_request == (|$past(receive_enable_mask));
    endproperty
    a_rx_on: assert property (p_rx_on) else $error("receiver request wrong");
    c_ack: cover property (ack_start);
    c_abort: cover property (tx_abort);
    c_rx_on: cover property (rx_on_request && receive_enable_mask[6]);
endmodule // rfhc_checker

// ---- bench/test_radio_frame_handling_control.sv ----
// Self-checking bench for the frame-handling control block
`timescale 1ns/100ps
`include "rfhc_defines.vh"
module test_radio_frame_handling_control;
    localparam [15:0] ACK = 16'd10;  // Shortened turnaround keeps the run brief
    reg         hclk, hresetn, hsel, hwrite, frame_done, frame_accepted, frame_ack_req, frame_crc_ok;
    reg         fsm_pending, rssi_valid, rx_fifo_overflow, tx_fifo_underflow;
    reg  [31:0] haddr, hwdata, rd;
    reg  [1:0]  htrans;
    reg  [2:0]  hsize;
    reg  [7:0]  rssi_sample;
    wire [31:0] hrdata;
    wire        hreadyout, hresp, ack_start, ack_pending, rx_sfd_search_en, rx_fifo_wrap, rx_stop;
    wire        tx_fifo_loop, tx_prbs_sel, tx_length_exact, tx_underflow_flag, tx_abort, rx_on_request;
    wire [7:0]  rssi_value, receive_enable_mask;
    integer     err_total, n_compared, i;
    integer     cyc = 0;
    // Single slave, so its ready is the bus ready
    rfhc_top #(.ACK_DELAY_CYC(ACK)) rfhc_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .frame_done, .frame_accepted, .frame_ack_req,
        .frame_crc_ok, .fsm_pending, .rssi_sample, .rssi_valid, .rx_fifo_overflow, .tx_fifo_underflow, .ack_start,
        .ack_pending, .rssi_value, .rx_sfd_search_en, .rx_fifo_wrap, .rx_stop, .tx_fifo_loop, .tx_prbs_sel,
        .tx_length_exact, .tx_underflow_flag, .tx_abort, .rx_on_request, .receive_enable_mask);
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // Hang guard
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            print_verdict;
        end
    end
    task print_verdict;
        begin
            $display("compared %0d mismatches %0d", n_compared, err_total);
            if (err_total == 0 && n_compared > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task check(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // One word transfer: address phase, then data phase; waits on ready
    task bus(input wr, input [15:0] idx, input [7:0] d);
        begin
            haddr <= {14'h0, idx, 2'h0};
            htrans <= 2'h2;
            hwrite <= wr;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            htrans <= 2'h0;
            hwdata <= {24'h0, d};
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            rd = hrdata;
        end
    endtask
    task rchk(input [15:0] idx, input [7:0] exp);
        begin
            bus(1'b0, idx, 8'h00);
            check(rd, {24'h0, exp});
        end
    endtask
    task settle(input [7:0] ctrl_a, input [7:0] ctrl_b);
        begin
            bus(1'b1, `RFHC_IDX_CTRL_A, ctrl_a);
            bus(1'b1, `RFHC_IDX_CTRL_B, ctrl_b);
            repeat (3) @(posedge hclk);
        end
    endtask
    task t_reset;
        begin
            rchk(`RFHC_IDX_CTRL_A, `RFHC_CTRL_A_RST);
            rchk(`RFHC_IDX_CTRL_B, 8'h01);
            rchk(`RFHC_IDX_MASK, 8'h00);
            rchk(16'h6200, 8'h00);
            check({hreadyout, hresp}, 2'h2);
            bus(1'b1, `RFHC_IDX_CTRL_B, 8'hff);
            rchk(`RFHC_IDX_CTRL_B, 8'h07);
        end
    endtask
    // Every mode code, reserved one included, with both FIFO faults present
    task t_modes;
        reg [1:0] m;
        begin
            rx_fifo_overflow <= 1'b1;
            tx_fifo_underflow <= 1'b1;
            for (i = 0; i < 4; i = i + 1) begin
                m = i;
                settle({4'h0, m, m}, 8'h02);
                check(rx_sfd_search_en, m != 2'h3);
                check(rx_fifo_wrap, m == 2'h2);
                check(rx_stop, m != 2'h2);
                check(tx_fifo_loop, m == 2'h2);
                check(tx_prbs_sel, m == 2'h3);
                check(tx_underflow_flag, !m[1]);
                rchk(`RFHC_IDX_CTRL_A, {4'h0, m, m});
            end
        end
    endtask
    task t_underflow;
        begin
            settle(8'h00, 8'h00);
            check(tx_abort, 1'b1);
            settle(8'h00, 8'h02);
            check({tx_abort, tx_length_exact}, 2'h1);
            tx_fifo_underflow <= 1'b0;
            rx_fifo_overflow <= 1'b0;
        end
    endtask
    task t_pending;
        begin
            fsm_pending <= 1'b0;
            settle(8'h00, 8'h04);
            check(ack_pending, 1'b1);
            settle(8'h00, 8'h00);
            check(ack_pending, 1'b0);
            fsm_pending <= 1'b1;
            repeat (2) @(posedge hclk);
            check(ack_pending, 1'b1);
        end
    endtask
    task t_mask;
        begin
            bus(1'b1, `RFHC_IDX_STROBE, 8'h01);
            rchk(`RFHC_IDX_MASK, 8'h00);
            settle(8'h00, 8'h01);
            bus(1'b1, `RFHC_IDX_STROBE, 8'h01);
            rchk(`RFHC_IDX_MASK, 8'h40);
            bus(1'b1, `RFHC_IDX_MASK_SET, 8'h21);
            rchk(`RFHC_IDX_MASK, 8'h61);
            check(rx_on_request, 1'b1);
            bus(1'b1, `RFHC_IDX_MASK_CLR, 8'hff);
            repeat (2) @(posedge hclk);
            check({rx_on_request, receive_enable_mask}, 9'h000);
        end
    endtask
    // Frame end, then the acknowledgement window edge by edge
    task ack_win(input ok, input exp);
        begin
            frame_done <= 1'b1;
            frame_crc_ok <= ok;
            @(posedge hclk);
            frame_done <= 1'b0;
            repeat (ACK) begin
                @(posedge hclk);
                check(ack_start, 1'b0);
            end
            @(posedge hclk);
            check(ack_start, exp);
            @(posedge hclk);
            check(ack_start, 1'b0);
        end
    endtask
    task t_ack;
        begin
            frame_accepted <= 1'b1;
            frame_ack_req <= 1'b1;
            settle(8'h20, 8'h00);
            ack_win(1'b0, 1'b0);
            ack_win(1'b1, 1'b1);
            settle(8'h00, 8'h00);
            ack_win(1'b1, 1'b0);
        end
    endtask
    task sample(input [7:0] v);
        begin
            rssi_sample <= v;
            rssi_valid <= 1'b1;
            @(posedge hclk);
            rssi_valid <= 1'b0;
            repeat (2) @(posedge hclk);
        end
    endtask
    // Negative sample checks the signed compare of the peak
    task t_peak;
        begin
            sample(8'h05);
            rchk(`RFHC_IDX_RSSI, 8'h05);
            settle(8'h10, 8'h00);
            sample(8'h14);
            sample(8'hfd);
            sample(8'h07);
            rchk(`RFHC_IDX_RSSI, 8'h14);
            settle(8'h00, 8'h00);
            sample(8'hfd);
            check(rssi_value, 8'hfd);
        end
    endtask
    initial begin
        {hresetn, hsel, hwrite, frame_done, frame_accepted, frame_ack_req, frame_crc_ok} = 7'h0;
        {fsm_pending, rssi_valid, rx_fifo_overflow, tx_fifo_underflow, htrans, rssi_sample} = 14'h0;
        {haddr, hwdata, rd} = 96'h0;
        hsize = 3'h2;
        err_total = 0;
        n_compared = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        hsel <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_modes;
        t_underflow;
        t_pending;
        t_mask;
        t_ack;
        t_peak;
        print_verdict;
    end
endmodule // test_radio_frame_handling_control
bind rfhc_top rfhc_checker #(.ACK_DELAY_CYC(ACK_DELAY_CYC)) rfhc_checker_inst (.hclk, .hresetn, .frame_done,
    .frame_accepted, .frame_ack_req, .frame_crc_ok, .tx_fifo_underflow, .ack_start, .rx_sfd_search_en, .rx_fifo_wrap,
    .rx_stop, .tx_fifo_loop, .tx_prbs_sel, .tx_length_exact, .tx_underflow_flag, .tx_abort, .rx_on_request,
    .receive_enable_mask);
